// ### lop_map.svh
`ifndef LOP_MAP_SVH
`define LOP_MAP_SVH

// register byte offsets
`define LOP_OFF_MODE 12'h000
`define LOP_OFF_SELECT 12'h004
`define LOP_OFF_GROUP_DUTY 12'h008
`define LOP_OFF_GROUP_FREQ 12'h00C
`define LOP_OFF_DUTY0 12'h010
`define LOP_OFF_STATUS 12'h020

// mode register field positions
`define LOP_MODE_INVERT 0
`define LOP_MODE_PUSH_PULL 1
`define LOP_MODE_DIM_BLINK 2
`define LOP_MODE_DIS_LO 3
`define LOP_MODE_DIS_HI 4

// reset values
`define LOP_RST_INVERT 1'h0
`define LOP_RST_PUSH_PULL 1'h1
`define LOP_RST_DIM_BLINK 1'h0
`define LOP_RST_DIS_STATE 2'h0
`define LOP_RST_GROUP_DUTY 8'hFF
`define LOP_RST_GROUP_FREQ 8'h00
`define LOP_RST_SELECT 8'h00
`define LOP_RST_DUTY 8'h00

// timing
`define LOP_CLK_HZ 200000000
`define LOP_IND_HZ 97000
`define LOP_DIM_HZ 190
`define LOP_BLINK_MAX_HZ 24
`define LOP_STEPS 256
`define LOP_IND_STEP_CYC (`LOP_CLK_HZ / (`LOP_IND_HZ * `LOP_STEPS))
`define LOP_DIM_STEP_CYC (`LOP_CLK_HZ / (`LOP_DIM_HZ * `LOP_STEPS))
`define LOP_BLINK_STEP_CYC (`LOP_CLK_HZ / (`LOP_BLINK_MAX_HZ * `LOP_STEPS))

`endif

// ### lop_pkg.sv
package lop_pkg;

   localparam int unsigned NCH = 4;

   typedef enum logic [1:0] {
      LOP_SEL_OFF,
      LOP_SEL_ON,
      LOP_SEL_IND,
      LOP_SEL_GRP
   } lop_sel_e;

   typedef struct packed {
      logic paddr_ok;
      logic [11:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } lop_apb_req_s;

   typedef struct packed {
      logic invert;
      logic push_pull;
      logic dim_blink;
      logic [1:0] dis_state;
      logic [7:0] group_duty;
      logic [7:0] group_freq;
      logic [NCH-1:0][1:0] sel;
      logic [NCH-1:0][7:0] duty;
      logic [2:0] oe_sync;
      logic oe_high;
      logic [2:0] ind_pre;
      logic [7:0] ind_cnt;
      logic [15:0] grp_pre;
      logic [7:0] grp_sub;
      logic [7:0] grp_cnt;
      logic [NCH-1:0] pin_o;
      logic [NCH-1:0] pin_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lop_state_s;

endpackage : lop_pkg

// ### lop_led_stage.sv
`timescale 1ns/1ps
`include "lop_map.svh"

module lop_led_stage #(
   parameter int unsigned DIM_STEP_CYC = `LOP_DIM_STEP_CYC,
   parameter int unsigned BLINK_STEP_CYC = `LOP_BLINK_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic output_enable_n,
   output logic [lop_pkg::NCH-1:0] led_output_pin_o,
   output logic [lop_pkg::NCH-1:0] led_output_pin_oe
);

   localparam logic [2:0] IND_LAST = 3'(`LOP_IND_STEP_CYC - 1);
   localparam logic [15:0] DIM_LAST = 16'(DIM_STEP_CYC - 1);
   localparam logic [15:0] BLINK_LAST = 16'(BLINK_STEP_CYC - 1);

   lop_pkg::lop_state_s q;
   lop_pkg::lop_state_s d;

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign led_output_pin_o = q.pin_o;
   assign led_output_pin_oe = q.pin_oe;

   always_comb begin
      logic [lop_pkg::NCH-1:0] active;
      logic grp_active;
      logic ind_active;
      logic access;
      logic hit;
      logic [31:0] rdata;
      logic [15:0] pre_last;
      active = '0;
      grp_active = 1'b0;
      ind_active = 1'b0;
      access = 1'b0;
      hit = 1'b0;
      rdata = '0;
      pre_last = '0;
      d = q;

      // pin is outside the clock domain: a change counts once stages 2 and 3 agree
      d.oe_sync = {q.oe_sync[1:0], output_enable_n};
      if (q.oe_sync[2] == q.oe_sync[1]) begin
         d.oe_high = q.oe_sync[2];
      end

      // shared fast counter: 8 clocks per step, 256 steps per period
      d.ind_pre = q.ind_pre + 3'h1;
      if (q.ind_pre == IND_LAST) begin
         d.ind_pre = 3'h0;
         d.ind_cnt = q.ind_cnt + 8'h01;
      end

      // one group generator, its pace set by the dim/blink choice
      pre_last = q.dim_blink ? BLINK_LAST : DIM_LAST;
      d.grp_pre = q.grp_pre + 16'h0001;
      if (q.grp_pre >= pre_last) begin
         d.grp_pre = 16'h0000;
         if (q.dim_blink && q.grp_sub < q.group_freq) begin
            d.grp_sub = q.grp_sub + 8'h01;
         end else begin
            d.grp_sub = 8'h00;
            d.grp_cnt = q.grp_cnt + 8'h01;
         end
      end
      grp_active = q.grp_cnt < q.group_duty;

      for (int i = 0; i < lop_pkg::NCH; i++) begin
         ind_active = q.ind_cnt < q.duty[i];
         case (lop_pkg::lop_sel_e'(q.sel[i]))
            lop_pkg::LOP_SEL_OFF: active[i] = 1'b0;
            lop_pkg::LOP_SEL_ON: active[i] = 1'b1;
            lop_pkg::LOP_SEL_IND: active[i] = ind_active;
            lop_pkg::LOP_SEL_GRP: active[i] = ind_active & grp_active;
            default: active[i] = 1'b0;
         endcase
         // inversion applied after the AND so both duties invert together
         active[i] = active[i] ^ q.invert;
         if (q.oe_high) begin
            d.pin_o[i] = q.dis_state == 2'h1;
            d.pin_oe[i] = (q.dis_state == 2'h0) | (q.dis_state == 2'h1 && q.push_pull);
         end else if (active[i]) begin
            d.pin_o[i] = 1'b0;
            d.pin_oe[i] = 1'b1;
         end else begin
            d.pin_o[i] = 1'b1;
            d.pin_oe[i] = q.push_pull;
         end
      end

      // apb: answer comes in the first cycle of the access phase, with no wait state
      access = psel & penable & q.pready;
      d.pready = psel & ~penable;
      case (paddr)
         `LOP_OFF_MODE: begin
            hit = 1'b1;
            rdata[`LOP_MODE_INVERT] = q.invert;
            rdata[`LOP_MODE_PUSH_PULL] = q.push_pull;
            rdata[`LOP_MODE_DIM_BLINK] = q.dim_blink;
            rdata[`LOP_MODE_DIS_HI:`LOP_MODE_DIS_LO] = q.dis_state;
         end
         `LOP_OFF_SELECT: begin
            hit = 1'b1;
            rdata[7:0] = q.sel;
         end
         `LOP_OFF_GROUP_DUTY: begin
            hit = 1'b1;
            rdata[7:0] = q.group_duty;
         end
         `LOP_OFF_GROUP_FREQ: begin
            hit = 1'b1;
            rdata[7:0] = q.group_freq;
         end
         `LOP_OFF_STATUS: begin
            hit = 1'b1;
            rdata[3:0] = q.pin_o;
            rdata[7:4] = q.pin_oe;
            rdata[8] = q.oe_high;
         end
         default: begin
            for (int i = 0; i < lop_pkg::NCH; i++) begin
               if (paddr == `LOP_OFF_DUTY0 + 12'(4 * i)) begin
                  hit = 1'b1;
                  rdata[7:0] = q.duty[i];
               end
            end
         end
      endcase
      // error flag pulses beside pready, so it never outlives its transfer
      d.pslverr = psel & ~penable & ~hit;
      if (psel & ~penable) begin
         d.prdata = pwrite ? 32'h0000_0000 : rdata;
      end
      if (access & pwrite & hit) begin
         case (paddr)
            `LOP_OFF_MODE: begin
               d.invert = pwdata[`LOP_MODE_INVERT];
               d.push_pull = pwdata[`LOP_MODE_PUSH_PULL];
               d.dim_blink = pwdata[`LOP_MODE_DIM_BLINK];
               d.dis_state = pwdata[`LOP_MODE_DIS_HI:`LOP_MODE_DIS_LO];
            end
            `LOP_OFF_SELECT: d.sel = pwdata[7:0];
            `LOP_OFF_GROUP_DUTY: d.group_duty = pwdata[7:0];
            `LOP_OFF_GROUP_FREQ: d.group_freq = pwdata[7:0];
            default: begin
               for (int i = 0; i < lop_pkg::NCH; i++) begin
                  if (paddr == `LOP_OFF_DUTY0 + 12'(4 * i)) begin
                     d.duty[i] = pwdata[7:0];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.invert <= `LOP_RST_INVERT;
         q.push_pull <= `LOP_RST_PUSH_PULL;
         q.dim_blink <= `LOP_RST_DIM_BLINK;
         q.dis_state <= `LOP_RST_DIS_STATE;
         q.group_duty <= `LOP_RST_GROUP_DUTY;
         q.group_freq <= `LOP_RST_GROUP_FREQ;
         q.sel <= `LOP_RST_SELECT;
         q.duty <= {lop_pkg::NCH{`LOP_RST_DUTY}};
         // assume disabled until the pin has been seen
         q.oe_sync <= 3'h7;
         q.oe_high <= 1'b1;
      end else begin
         q <= d;
      end
   end

endmodule : lop_led_stage

// ### lop_led_load.sv
`timescale 1ns/1ps
// pull-up load: a released pin reads high, never the last driven level
module lop_led_load (
   input wire logic [lop_pkg::NCH-1:0] pin_o,
   input wire logic [lop_pkg::NCH-1:0] pin_oe,
   output logic [lop_pkg::NCH-1:0] level
);
   assign level = pin_o | ~pin_oe;
endmodule : lop_led_load

// ### lop_led_stage_asserts.sv
`timescale 1ns/1ps
module lop_led_stage_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic output_enable_n,
   input wire logic [lop_pkg::NCH-1:0] led_output_pin_o,
   input wire logic [lop_pkg::NCH-1:0] led_output_pin_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RDY_SETUP: assert property (psel && !penable |=> pready) else $error("pready late");
   AST_RDY_ACCESS: assert property (pready |-> psel && penable) else $error("stray pready");
   AST_RDY_PULSE: assert property (pready |=> !pready) else $error("pready held");
   AST_ERR_RDY: assert property (pslverr |-> pready) else $error("stray pslverr");
   AST_ERR_ADDR: assert property (pready |-> pslverr == (paddr > 12'h020 || paddr[1:0] != 2'h0))
      else $error("pslverr wrong");
   AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
   AST_HI_ZERO: assert property (pready && !pwrite |-> prdata[31:9] == 23'h0) else $error("hi bits");
   AST_DIS_SAME: assert property (output_enable_n [*6] |->
      (&led_output_pin_o || ~|led_output_pin_o) && (&led_output_pin_oe || ~|led_output_pin_oe))
      else $error("disabled pins differ");
endmodule : lop_led_stage_asserts

bind lop_led_stage lop_led_stage_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pready, .pslverr, .output_enable_n, .led_output_pin_o, .led_output_pin_oe);

// ### lop_led_stage_tb.sv
`timescale 1ns/1ps
module lop_led_stage_tb;
   localparam int N = lop_pkg::NCH;
   logic pclk, presetn, psel, penable, pwrite, oe_n, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [N-1:0] pin_o, pin_oe, lvl;
   logic [32:0] rsp;
   int miscompares, n_compared, e, m[8], cnt[N];
   // blink steps of 2 or 4 clocks keep every group period a divisor of 1024 clocks
   lop_led_stage #(.DIM_STEP_CYC(4), .BLINK_STEP_CYC(2)) DUT (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .output_enable_n(oe_n), .led_output_pin_o(pin_o), .led_output_pin_oe(pin_oe));
   lop_led_load u_load (.pin_o, .pin_oe, .level(lvl));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %0h, expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("%0d compared, %0d wrong", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic apb(input logic w, input int r, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, 12'(r * 4), d};
      @(posedge pclk);
      penable <= 1'b1;
      // outputs are looked at mid-cycle, where they have settled
      @(negedge pclk);
      for (int i = 0; i < 20 && pready !== 1'b1; i++) @(negedge pclk);
      if (pready !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      rsp = {pslverr, prdata};
      // the request stands through the edge at which pready is high
      @(posedge pclk);
      {psel, penable} <= 2'h0;
      // model keeps only the bits the block implements
      if (w && r < 8) m[r] = d & (r == 0 ? 32'h1F : 32'hFF);
   endtask : apb
   task automatic rdall;
      for (int r = 0; r < 10; r++) begin
         apb(1'b0, r, 32'h0);
         chk(r == 8 ? rsp[8] : rsp[31:0], r < 8 ? m[r] : 0);
         chk(rsp[32], r > 8);
      end
      $display("register test done");
   endtask : rdall
   task automatic pins(input logic [1:0] x);
      repeat (8) @(posedge pclk);
      @(negedge pclk);
      for (int c = 0; c < N; c++) chk({pin_oe[c], lvl[c]}, x);
      @(posedge pclk);
   endtask : pins
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, oe_n, paddr, pwdata} = '0;
      void'($urandom(32'hDEA86DEB));
      m = '{32'h2, 0, 32'hFF, 0, 0, 0, 0, 0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdall();
      // duty 0 makes codes 10 and 11 static, so every selector code is checked here
      for (int k = 0; k < 16; k++) begin
         apb(1'b1, 1, {4{k[3:2]}});
         apb(1'b1, 0, {k[3:2], 1'b0, k[1:0]});
         e = (k[3:2] == 2'h1) ^ k[0];
         pins({e[0] | k[1], !e[0]});
         oe_n <= 1'b1;
         pins(k[3] ? 2'h1 : k[2] ? {k[1], 1'b1} : 2'h2);
         oe_n <= 1'b0;
      end
      $display("static pin test done");
      for (int p = 0; p < 4; p++) begin
         // duty 128 spans 1024 clocks, whole group periods, so the overlap is phase free
         for (int c = 0; c < N; c++) apb(1'b1, 4 + c, p[1] ? 32'h80 : $urandom);
         apb(1'b1, 2, p[1] ? $urandom : 32'hFF);
         apb(1'b1, 3, {31'h0, 1'($urandom)});
         apb(1'b1, 1, p[1] ? 32'hFF : 32'hAA);
         apb(1'b1, 0, {1'($urandom), 1'b1, p[0]});
         repeat (8) @(posedge pclk);
         cnt = '{default: 0};
         repeat (2048) begin
            @(negedge pclk);
            foreach (cnt[c]) cnt[c] += int'(lvl[c] !== 1'b1);
         end
         foreach (cnt[c]) begin
            e = p[1] ? m[2] * 4 : m[4 + c] * 8;
            chk(cnt[c], p[0] ? 2048 - e : e);
         end
      end
      $display("pwm test done");
      rdall();
      end_sim();
   end
endmodule : lop_led_stage_tb
